/* File: enc_chk.sv */
`timescale 1ns/100ps
module enc_chk #(parameter int POWER_ON_CYCLES = 20) (
    input wire logic clk,
    input wire logic reset_n,
    input enc_out_pkg::output_cfg_t cfg,
    input wire logic error_active,
    input enc_out_pkg::pin_out_t pins,
    input wire logic slewing,
    input wire logic fine_code_misuse
);
    logic [15:0] q_r;
    logic [15:0] held_r;
    logic ok;
    logic enc;
    // Only judge steady stepping once config and errors are quiet
    assign ok = q_r > 16'(POWER_ON_CYCLES + 40);
    assign enc = !cfg.output_protocol_select;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // Quiet time and A/B dwell counters
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            q_r <= 16'h0;
            held_r <= 16'h0;
        end else begin
            q_r <= (cfg != $past(cfg) || error_active) ? 16'h0 : q_r + 16'h1;
            held_r <= $changed(pins.level[1:0]) ? 16'h1 : held_r + 16'h1;
        end
    end
    a_pin_enable: assert property ($past(reset_n)
        |-> pins.enable == {3{$past(cfg.encoder_output_enable)}}) else $error("enable wrong");
    a_gray_step: assert property (ok && enc && cfg.slew_time_code != 6'h0
        |-> $countones(pins.level[1:0] ^ $past(pins.level[1:0])) < 2) else $error("skip");
    a_slew_hold: assert property (ok && enc && cfg.slew_time_code != 6'h0
        && $changed(pins.level[1:0]) |-> held_r >= 16'(((cfg.slew_time_code + 7'h1) * 125 + 9) / 10))
        else $error("short hold");
    a_error_shown: assert property ((enc && cfg.error_report_enable && error_active
        && !cfg.output_polarity_invert)[*2] |=> pins.level == enc_out_pkg::ERROR_PATTERN)
        else $error("no error pattern");
    a_code_idle: assert property ((enc && !cfg.error_report_enable && $stable(cfg)
        && cfg.output_resolution_code inside {4'h0, 4'h1, 4'hF})[*2]
        |=> pins.level == {3{cfg.output_polarity_invert}}) else $error("idle code drives");
    a_no_slew: assert property ((cfg.slew_time_code == 6'h0)[*3] |-> !slewing)
        else $error("slewing at zero");
    a_uvw_legal: assert property (ok && !enc && !cfg.error_report_enable
        |-> pins.level != 3'h0 && pins.level != 3'h7) else $error("bad phase");
    a_fine_flag: assert property (enc |-> fine_code_misuse == (cfg.output_channel_select
        && cfg.output_resolution_code inside {[4'h2:4'h5]})) else $error("flag wrong");
    c_slewing: cover property (slewing);
    c_error: cover property (error_active && pins.level == enc_out_pkg::ERROR_PATTERN);
    c_uvw: cover property (!enc && pins.level == 3'h5);
endmodule
bind encoder_commutation_output enc_chk #(.POWER_ON_CYCLES(POWER_ON_CYCLES)) u_chk (.clk,
    .reset_n, .cfg, .error_active, .pins, .slewing, .fine_code_misuse);

/* File: enc_out_pkg.sv */
package enc_out_pkg;

    // Clock and start-up timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int POWER_ON_DELAY_MS = 16;
    localparam int POWER_ON_DELAY_CYCLES = POWER_ON_DELAY_MS * 1000000 / CLK_PERIOD_NS;

    // One slew step lasts (code + 1) units of this many ns
    localparam int SLEW_UNIT_NS = 125;
    localparam int SLEW_CNT_W = 10;

    // Angle and resolution layout
    localparam int ANGLE_W = 16;
    localparam logic [3:0] RES_FIRST_VALID = 4'h2;
    localparam logic [3:0] RES_LAST_VALID = 4'hE;
    localparam logic [3:0] RES_FINE_LAST = 4'h5;

    // Pin pattern shown while an error is reported (A/U, B/V, I/W)
    localparam logic [2:0] ERROR_PATTERN = 3'h7;
    localparam logic [2:0] IDLE_PATTERN = 3'h0;

    // Protocol and channel encodings
    localparam logic PROTO_ENCODER = 1'b0;
    localparam logic PROTO_COMMUTATION = 1'b1;
    localparam logic CHANNEL_PRIMARY = 1'b0;

    // Start-up and error sequencing
    typedef enum logic [1:0] {
        ST_POWER_ON = 2'b00,
        ST_ERROR = 2'b01,
        ST_RUN = 2'b10
    } run_state_t;

    // Static configuration of the output stage
    typedef struct packed {
        logic output_protocol_select;
        logic output_channel_select;
        logic encoder_output_enable;
        logic output_polarity_invert;
        logic [1:0] index_width_mode;
        logic [3:0] output_resolution_code;
        logic [5:0] slew_time_code;
        logic startup_countup_disable;
        logic error_report_enable;
    } output_cfg_t;

    // Angles from the two sensing channels
    typedef struct packed {
        logic [ANGLE_W-1:0] primary_angle;
        logic [ANGLE_W-1:0] secondary_angle;
    } angle_in_t;

    // Three shared output pins
    typedef struct packed {
        logic [2:0] level;
        logic [2:0] enable;
    } pin_out_t;

endpackage

/* File: encoder_commutation_output.sv */
`timescale 1ns/100ps
// Overview of operation
// - One bit picks encoder or commutation output
// - One bit picks primary or secondary channel
// - Enable bit switches the output pins
// - One code sets resolution and pole pairs
// - Invert bit flips every pin level
// - Codes 2..14 give 2^(14-code) cycles
// - Codes 0 and 1 are factory only
// - Commutation pole pairs equal code plus one
// - Index pulse width set by two-bit mode
// - Power-on delay shows error-reporting state
// - Catch-up takes shorter direction, then normal
// - Zero slew code jumps output immediately
// - Nonzero slew counts up after reset, errors
// - Count-up disable works only with error reporting
// - Zero at index rising edge up, falling down
// - Index width from resolution and mode
// - Quadrature follows Gray 00,01,11,10 order
// - Each state held at least slew time
// - Phases switch at pole-pair sector boundaries
module encoder_commutation_output #(
    parameter int POWER_ON_CYCLES = enc_out_pkg::POWER_ON_DELAY_CYCLES
) (
    input wire logic clk,
    input wire logic reset_n,
    input enc_out_pkg::output_cfg_t cfg,
    input enc_out_pkg::angle_in_t angles,
    input wire logic error_active,
    output enc_out_pkg::pin_out_t pins,
    output logic slewing,
    output logic fine_code_misuse
);

    localparam int AW = enc_out_pkg::ANGLE_W;

    // A zero start-up count would wrap the limit and hold the power-on state for 2^32 cycles
    if (POWER_ON_CYCLES < 1) begin : g_bad_power_on
        $error("POWER_ON_CYCLES must be at least one");
    end

    // Minimum hold per state in cycles, rounded up
    function automatic logic [enc_out_pkg::SLEW_CNT_W-1:0] slew_cycles(input logic [5:0] code);
        int c;
        c = ((int'(code) + 1) * enc_out_pkg::SLEW_UNIT_NS + enc_out_pkg::CLK_PERIOD_NS - 1)
            / enc_out_pkg::CLK_PERIOD_NS;
        return c[enc_out_pkg::SLEW_CNT_W-1:0];
    endfunction

    // Mask of quadrature-state counter for a resolution code
    function automatic logic [AW-1:0] quad_mask(input logic [3:0] code);
        return 16'hFFFF >> code;
    endfunction

    // True for codes that define an encoder output
    function automatic logic res_valid(input logic [3:0] code);
        return (code >= enc_out_pkg::RES_FIRST_VALID) && (code <= enc_out_pkg::RES_LAST_VALID);
    endfunction

    enc_out_pkg::run_state_t state_r;
    logic [31:0] po_cnt_r;
    logic [AW-1:0] pos_r;
    logic [enc_out_pkg::SLEW_CNT_W-1:0] hold_r;
    logic [2:0] level_r;
    logic [2:0] enable_r;
    logic slewing_r;
    logic first_run_r;

    logic [AW-1:0] angle_sel;
    logic [AW-1:0] target;
    logic [AW-1:0] mask;
    logic [AW-1:0] diff;
    logic [AW-1:0] half;
    logic step_up;
    logic step_dn;
    logic jump;
    logic enc_valid;
    logic [2:0] raw_level;
    logic [AW+4:0] elec_prod;
    logic [AW-1:0] elec_angle;
    logic [AW+2:0] sector_prod;
    logic [2:0] sector;
    logic [2:0] phase_level;
    logic [2:0] quad_level;
    logic index_level;
    logic [AW-1:0] index_width;
    logic countup_off;

    assign angle_sel = (cfg.output_channel_select == enc_out_pkg::CHANNEL_PRIMARY) ?
        angles.primary_angle : angles.secondary_angle;

    assign fine_code_misuse = (cfg.output_channel_select != enc_out_pkg::CHANNEL_PRIMARY) &&
        res_valid(cfg.output_resolution_code) &&
        (cfg.output_resolution_code <= enc_out_pkg::RES_FINE_LAST);

    // one code sets resolution and pole pairs
    assign mask = quad_mask(cfg.output_resolution_code);
    assign target = (angle_sel >> cfg.output_resolution_code) & mask;
    assign half = (mask >> 1) + 16'h0001;
    assign diff = (target - pos_r) & mask;

    assign step_up = (diff != 16'h0000) && (diff < half);
    assign step_dn = (diff != 16'h0000) && !(diff < half);

    // zero slew code means immediate jump
    assign jump = (cfg.slew_time_code == 6'h00);

    // codes 0, 1 and 15 are not encoder resolutions
    assign enc_valid = res_valid(cfg.output_resolution_code);

    // suppression only with error reporting enabled
    assign countup_off = cfg.startup_countup_disable && cfg.error_report_enable;

    // Start-up delay, error reporting and run sequencing
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= enc_out_pkg::ST_POWER_ON;
            po_cnt_r <= 32'h00000000;
            first_run_r <= 1'b1;
        end else begin
            unique case (state_r)
                enc_out_pkg::ST_POWER_ON: begin
                    if (po_cnt_r >= 32'(POWER_ON_CYCLES - 1)) begin
                        state_r <= enc_out_pkg::ST_RUN;
                    end else begin
                        po_cnt_r <= po_cnt_r + 32'h00000001;
                    end
                end
                enc_out_pkg::ST_RUN: begin
                    first_run_r <= 1'b0;
                    if (cfg.error_report_enable && error_active) begin
                        state_r <= enc_out_pkg::ST_ERROR;
                    end
                end
                enc_out_pkg::ST_ERROR: begin
                    if (!(cfg.error_report_enable && error_active)) begin
                        state_r <= enc_out_pkg::ST_RUN;
                    end
                end
                default: begin
                    state_r <= enc_out_pkg::ST_POWER_ON;
                end
            endcase
        end
    end

    // Output position counter with slew limiting
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pos_r <= 16'h0000;
            hold_r <= '0;
            slewing_r <= 1'b0;
        end else if (state_r != enc_out_pkg::ST_RUN) begin
            // restart count-up from zero after reset or error
            pos_r <= 16'h0000;
            hold_r <= '0;
            slewing_r <= 1'b0;
        end else if (jump || (first_run_r && countup_off)) begin
            pos_r <= target;
            hold_r <= '0;
            slewing_r <= 1'b0;
        end else if (hold_r != '0) begin
            hold_r <= hold_r - 1'b1;
        end else if (step_up || step_dn) begin
            pos_r <= (step_up ? pos_r + 16'h0001 : pos_r - 16'h0001) & mask;
            hold_r <= slew_cycles(cfg.slew_time_code) - 1'b1;
            slewing_r <= (diff != 16'h0001) && (diff != mask);
        end else begin
            slewing_r <= 1'b0;
        end
    end

    // Gray coding of the two low position bits
    assign quad_level[0] = pos_r[1];
    assign quad_level[1] = pos_r[1] ^ pos_r[0];

    // width of index in quadrature states
    // width scales with resolution through pos units
    assign index_width = {14'h0000, cfg.index_width_mode} + 16'h0001;

    // index starts at zero going up, ends at zero going down
    assign index_level = (pos_r < index_width);
    assign quad_level[2] = index_level;

    // electrical angle for code plus one pole pairs
    assign elec_prod = angle_sel * ({1'b0, cfg.output_resolution_code} + 5'h01);
    assign elec_angle = elec_prod[AW-1:0];

    // six commutation sectors per electrical cycle
    assign sector_prod = elec_angle * 3'h6;
    assign sector = sector_prod[AW+2:AW];

    // Six-step U, V, W pattern
    always_comb begin
        unique case (sector)
            3'h0: phase_level = 3'h1;
            3'h1: phase_level = 3'h3;
            3'h2: phase_level = 3'h2;
            3'h3: phase_level = 3'h6;
            3'h4: phase_level = 3'h4;
            3'h5: phase_level = 3'h5;
            default: phase_level = 3'h1;
        endcase
    end

    // Raw pin levels before polarity
    always_comb begin
        if (state_r != enc_out_pkg::ST_RUN) begin
            // error-reporting view during delay and errors
            raw_level = cfg.error_report_enable ? enc_out_pkg::ERROR_PATTERN :
                enc_out_pkg::IDLE_PATTERN;
        end else if (cfg.output_protocol_select == enc_out_pkg::PROTO_COMMUTATION) begin
            raw_level = phase_level;
        end else if (!enc_valid) begin
            raw_level = enc_out_pkg::IDLE_PATTERN;
        end else begin
            raw_level = quad_level;
        end
    end

    // Registered pin drive; inversion kept after selection so it hits both modes
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            level_r <= 3'h0;
            enable_r <= 3'h0;
        end else begin
            level_r <= cfg.output_polarity_invert ? ~raw_level : raw_level;
            enable_r <= {3{cfg.encoder_output_enable}};
        end
    end

    assign pins.level = level_r;
    assign pins.enable = enable_r;
    assign slewing = slewing_r;

endmodule

/* File: quad_rx.sv */
`timescale 1ns/100ps
module quad_rx (
    input wire logic clk,
    input wire logic reset_n,
    input enc_out_pkg::pin_out_t pins,
    output int count
);
    logic [2:0] lvl;
    logic [1:0] idx;
    logic [1:0] prev_r;
    // Released pins read high through the pull-up
    assign lvl = pins.level | ~pins.enable;
    assign idx = {lvl[0], lvl[0] ^ lvl[1]};
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            prev_r <= 2'h0;
            count <= 0;
        end else begin
            prev_r <= idx;
            case (2'(idx - prev_r))
                2'h1: count <= count + 1;
                2'h3: count <= count - 1;
                default: ;
            endcase
        end
    end
endmodule

/* File: tb.sv */
`timescale 1ns/100ps
module tb;
    logic clk;
    logic reset_n;
    enc_out_pkg::output_cfg_t cfg;
    enc_out_pkg::angle_in_t angles;
    logic error_active;
    enc_out_pkg::pin_out_t pins;
    logic slewing;
    int count;
    int c0;
    int n_errors = 0;
    int checked = 0;
    int cycles = 0;
    logic [3:0] rsv [3] = '{4'h0, 4'h1, 4'hF};
    logic [2:0] uvw [6] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5};
    encoder_commutation_output #(.POWER_ON_CYCLES(20)) DUT (.clk, .reset_n, .cfg, .angles,
        .error_active, .pins, .slewing, .fine_code_misuse());
    quad_rx rx (.clk, .reset_n, .pins, .count);
    // Clock and hang guard
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            close_out();
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR %s exp %0h got %0h", nm, e, g);
        end
    endtask
    // Angle in, two-cycle path, then compare pins
    task automatic go(input logic [15:0] a, input logic [2:0] e, input string nm);
        angles.primary_angle = a;
        tick(3);
        chk(nm, 32'(e), 32'(pins.level));
    endtask
    task automatic t_quad;
        go(16'h0000, 3'h4, "q0");
        go(16'h4000, 3'h2, "q1");
        go(16'hC000, 3'h1, "q3");
        cfg.output_resolution_code = 4'h2;
        cfg.index_width_mode = 2'h3;
        go(16'h000C, 3'h5, "w3");
        go(16'h0010, 3'h0, "w4");
        cfg.index_width_mode = 2'h0;
        cfg.output_resolution_code = 4'hE;
        cfg.output_polarity_invert = 1'b1;
        go(16'h4000, 3'h5, "inv");
        cfg.output_polarity_invert = 1'b0;
        cfg.output_channel_select = 1'b1;
        angles.secondary_angle = 16'hC000;
        go(16'h0000, 3'h1, "sec");
        cfg.output_channel_select = 1'b0;
        cfg.encoder_output_enable = 1'b0;
        for (int i = 0; i < 3; i++) begin
            cfg.output_resolution_code = rsv[i];
            go(16'h4000, 3'h0, "rsv");
            chk("off", 32'h0, 32'(pins.enable));
        end
        cfg.encoder_output_enable = 1'b1;
        $display("done quad");
    endtask
    task automatic t_uvw;
        cfg.output_protocol_select = 1'b1;
        cfg.output_resolution_code = 4'h0;
        tick(60);
        for (int s = 0; s < 6; s++) begin
            go(16'(s * 'h2AAB + 'h100), uvw[s], "uvw");
        end
        cfg.output_resolution_code = 4'hF;
        go(16'h0B00, 3'h4, "pp16");
        cfg.output_polarity_invert = 1'b1;
        go(16'h0100, 3'h6, "uinv");
        cfg.output_polarity_invert = 1'b0;
        cfg.output_protocol_select = 1'b0;
        $display("done uvw");
    endtask
    task automatic t_slew;
        cfg.output_resolution_code = 4'hC;
        go(16'h5000, 3'h2, "jump");
        go(16'h0000, 3'h4, "home");
        cfg.slew_time_code = 6'h1;
        c0 = count;
        angles.primary_angle = 16'h5000;
        tick(4);
        chk("slw", 32'h1, 32'(slewing));
        angles.primary_angle = 16'hF000;
        tick(400);
        chk("net", 32'(-1), 32'(count - c0));
        $display("done slew");
    endtask
    task automatic t_err;
        cfg.error_report_enable = 1'b1;
        error_active = 1'b1;
        tick(4);
        chk("err", 32'(enc_out_pkg::ERROR_PATTERN), 32'(pins.level));
        angles.primary_angle = 16'h3000;
        error_active = 1'b0;
        tick(4);
        chk("cup", 32'h1, 32'(slewing));
        tick(150);
        chk("cpos", 32'h1, 32'(pins.level));
        cfg.error_report_enable = 1'b0;
        cfg.slew_time_code = 6'h0;
        $display("done err");
    endtask
    // Mid-run reset with the start-up count-up suppressed
    task automatic t_boot;
        cfg.error_report_enable = 1'b1;
        cfg.startup_countup_disable = 1'b1;
        cfg.slew_time_code = 6'h1;
        angles.primary_angle = 16'h5000;
        reset_n = 1'b0;
        tick(2);
        chk("rst_en", 32'h0, 32'(pins.enable));
        reset_n = 1'b1;
        tick(5);
        chk("po_err", 32'(enc_out_pkg::ERROR_PATTERN), 32'(pins.level));
        tick(25);
        chk("no_cup", 32'h2, 32'(pins.level));
        chk("no_slw", 32'h0, 32'(slewing));
        $display("done boot");
    endtask
    task automatic close_out;
        $display("checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Reset, then the scenarios in order
    initial begin
        reset_n = 1'b0;
        cfg = '0;
        cfg.encoder_output_enable = 1'b1;
        cfg.output_resolution_code = 4'hE;
        angles = '0;
        error_active = 1'b0;
        tick(6);
        reset_n = 1'b1;
        tick(5);
        chk("boot", 32'(enc_out_pkg::IDLE_PATTERN), 32'(pins.level));
        tick(30);
        t_quad();
        t_uvw();
        t_slew();
        t_err();
        t_boot();
        close_out();
    end
endmodule
